// >>> pkg/sldi_pkg.sv
// Purpose: Shared constants and carrier types of the lane data interface.
// Assumes: One core clock; lane clocks are sampled as ordinary inputs.
// Notes: Summary of operation follows.
// Summary of operation
// R1: Ten transmit word buses, one per lane.
// R2: Lane bus is 80 bits wide or 32 bits.
// R3: Only lanes zero to three carry 80 bits.
// R4: Ten-lane mode uses low 32 bits only.
// R5: Wide lanes split into 16-bit aux, 64-bit main.
// R6: Receive word sampled on own recovered clock edge.
// R7: Far side holds reset while clock frequency wrong.
// R8: Far side holds reset until clock stable.
// R9: Far side may derive reset from PLL lock.
// R10: Each lane reset handled per lane, own clock.
// R11: Receive buses mirror the transmit lane layout.
// R12: Transmit lane updates only on own clock edge.
package sldi_pkg;
    localparam int LANES = 10;
    localparam int WIDE_LANES = 4;
    localparam int NARROW_LANES = 6;
    localparam int AUX_W = 16;
    localparam int WIDE_W = 64;
    localparam int NARROW_W = 32;
    localparam int FIFO_DEPTH = 8;
    localparam logic MODE_RESET = 1'h0;

    typedef struct packed {
        logic [WIDE_LANES-1:0][WIDE_W-1:0] wide;
        logic [NARROW_LANES-1:0][NARROW_W-1:0] narrow;
    } sldi_main_t;

    typedef struct packed {
        logic [WIDE_LANES-1:0][AUX_W-1:0] aux;
        sldi_main_t main;
    } sldi_lanes_t;

    localparam sldi_lanes_t LANES_RESET = '0;

    typedef struct packed {
        logic mode;
        logic [LANES-1:0] tx_s1;
        logic [LANES-1:0] tx_s2;
        logic [LANES-1:0] tx_s3;
        logic [LANES-1:0] rx_s1;
        logic [LANES-1:0] rx_s2;
        logic [LANES-1:0] rx_s3;
        logic [LANES-1:0] rst_s1;
        logic [LANES-1:0] rst_s2;
        logic [LANES-1:0] rx_new;
        sldi_lanes_t rxd_s1;
        sldi_lanes_t rxd_s2;
        sldi_lanes_t rxd_s3;
        sldi_lanes_t stage;
        sldi_lanes_t tx_out;
        sldi_lanes_t rx_out;
    } sldi_top_state_t;
endpackage : sldi_pkg

// >>> src/sldi_top.sv
// Purpose: Per-lane transmit and receive word interface to ten transceiver lanes.
// Assumes: Lane clocks are much slower than REF_CLK and are sampled by it.
// Notes: Transmit words pass an eight-word FIFO; receive words leave per lane.
`timescale 1ns/1ps
`default_nettype none

module sldi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Fill side.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side.
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
        logic full;
        logic empty;
        logic ready;
    } sldi_fifo_state_t;

    sldi_fifo_state_t r;
    sldi_fifo_state_t next_r;
    logic push;
    logic pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_check
        $error("FIFO depth must be a power of two of at least two.");
    end

    assign push = in_valid & ~r.full;
    assign pop = out_ready & ~r.empty;
    // Ready is a register of its own so that the fill side sees a flip-flop.
    assign in_ready = r.ready;
    assign out_valid = ~r.empty;
    assign out_data = r.mem[r.rd[AW-1:0]];

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wr[AW-1:0]] = in_data;
            next_r.wr = r.wr + (AW+1)'(1);
        end
        if (pop) begin
            next_r.rd = r.rd + (AW+1)'(1);
        end
        next_r.empty = (next_r.wr == next_r.rd);
        next_r.full = (next_r.wr[AW] != next_r.rd[AW]) &&
            (next_r.wr[AW-1:0] == next_r.rd[AW-1:0]);
        next_r.ready = !next_r.full;
        if (reset) begin
            next_r = '0;
            next_r.empty = 1'h1;
            next_r.ready = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    // Checks on the fill level, the ready flag and the pointers.
    fifo_ready_a: assert property (@(posedge clk) disable iff (reset) // R1
        in_ready == !r.full)
        else $error("FIFO ready flag disagrees with the full flag.");
    fifo_fill_a: assert property (@(posedge clk) disable iff (reset) // R1
        push |=> !r.empty)
        else $error("FIFO empty after a word was stored.");
    fifo_full_a: assert property (@(posedge clk) disable iff (reset) // R1
        push && !pop && (r.wr - r.rd == (AW+1)'(DEPTH - 1)) |=> r.full && !in_ready)
        else $error("FIFO not full after its last free slot was used.");
    fifo_last_a: assert property (@(posedge clk) disable iff (reset) // R1
        pop && !push && (r.wr - r.rd == (AW+1)'(1)) |=> r.empty && !out_valid)
        else $error("FIFO not empty after its last word was taken.");
    fifo_refuse_a: assert property (@(posedge clk) disable iff (reset) // R1
        in_valid && !in_ready |=> $stable(r.wr))
        else $error("FIFO stored a word while it was full.");
    fifo_wr_hold_a: assert property (@(posedge clk) disable iff (reset) // R1
        !push |=> $stable(r.wr))
        else $error("FIFO write pointer moved without a store.");
    fifo_rd_hold_a: assert property (@(posedge clk) disable iff (reset) // R1
        !pop |=> $stable(r.rd))
        else $error("FIFO read pointer moved without a take.");
endmodule : sldi_fifo

module sldi_top #(
    parameter int FIFO_DEPTH = sldi_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic RESET,
    // User control.
    input wire logic MODE_CAUI10,
    // User transmit words.
    input wire sldi_pkg::sldi_lanes_t TX_USER_WORD,
    input wire logic TX_VALID,
    output logic TX_READY,
    // User receive words.
    output sldi_pkg::sldi_lanes_t RX_USER_WORD,
    output logic [sldi_pkg::LANES-1:0] RX_NEW,
    // Transmit lanes.
    input wire logic [sldi_pkg::LANES-1:0] TX_LANE_CLOCK,
    output logic [sldi_pkg::WIDE_LANES-1:0][sldi_pkg::AUX_W-1:0] TX_LANE_AUX_GROUP,
    output sldi_pkg::sldi_main_t TX_LANE_MAIN_WORD,
    // Receive lanes.
    input wire logic [sldi_pkg::LANES-1:0] RX_LANE_RECOVERED_CLOCK,
    input wire logic [sldi_pkg::LANES-1:0] RX_LANE_RESET,
    input wire logic [sldi_pkg::WIDE_LANES-1:0][sldi_pkg::AUX_W-1:0] RX_LANE_AUX_GROUP,
    input wire sldi_pkg::sldi_main_t RX_LANE_MAIN_WORD
);
    sldi_pkg::sldi_top_state_t r;
    sldi_pkg::sldi_top_state_t next_r;
    logic [sldi_pkg::LANES-1:0] tx_edge;
    logic [sldi_pkg::LANES-1:0] rx_edge;
    sldi_pkg::sldi_lanes_t fifo_word;
    logic fifo_valid;
    logic fifo_pop;

    if (FIFO_DEPTH < 2) begin : g_check
        $error("FIFO depth must be at least two.");
    end

    // Keeps the low narrow word of a wide lane and clears the rest.
    function automatic logic [sldi_pkg::WIDE_W-1:0] low_only(
        input logic [sldi_pkg::WIDE_W-1:0] w);
        low_only = '0;
        low_only[sldi_pkg::NARROW_W-1:0] = w[sldi_pkg::NARROW_W-1:0];
    endfunction : low_only

    sldi_fifo #(
        .WIDTH($bits(sldi_pkg::sldi_lanes_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .reset(RESET),
        .in_data(TX_USER_WORD),
        .in_valid(TX_VALID),
        .in_ready(TX_READY),
        .out_data(fifo_word),
        .out_valid(fifo_valid),
        .out_ready(tx_edge[0])
    );

    assign tx_edge = r.tx_s2 & ~r.tx_s3;
    assign rx_edge = r.rx_s2 & ~r.rx_s3;
    assign fifo_pop = tx_edge[0] & fifo_valid;

    assign TX_LANE_AUX_GROUP = r.tx_out.aux;
    assign TX_LANE_MAIN_WORD = r.tx_out.main;
    assign RX_USER_WORD = r.rx_out;
    assign RX_NEW = r.rx_new;

    always_comb begin
        next_r = r;
        next_r.mode = MODE_CAUI10;
        next_r.tx_s1 = TX_LANE_CLOCK;
        next_r.tx_s2 = r.tx_s1;
        next_r.tx_s3 = r.tx_s2;
        next_r.rx_s1 = RX_LANE_RECOVERED_CLOCK;
        next_r.rx_s2 = r.rx_s1;
        next_r.rx_s3 = r.rx_s2;
        next_r.rst_s1 = RX_LANE_RESET;
        next_r.rst_s2 = r.rst_s1;
        next_r.rxd_s1.aux = RX_LANE_AUX_GROUP;
        next_r.rxd_s1.main = RX_LANE_MAIN_WORD;
        next_r.rxd_s2 = r.rxd_s1;
        next_r.rxd_s3 = r.rxd_s2;
        next_r.rx_new = '0;
        if (fifo_pop) begin
            next_r.stage = fifo_word;
        end
        for (int i = 0; i < sldi_pkg::WIDE_LANES; i++) begin
            if (tx_edge[i]) begin
                next_r.tx_out.aux[i] = r.mode ? '0 : r.stage.aux[i]; // R4 R5 R12
                next_r.tx_out.main.wide[i] = r.mode ? low_only(r.stage.main.wide[i]) :
                    r.stage.main.wide[i]; // R2 R4 R5 R12
            end
            if (r.rst_s2[i]) begin
                next_r.rx_out.aux[i] = '0; // R10
                next_r.rx_out.main.wide[i] = '0;
            end else if (rx_edge[i]) begin
                next_r.rx_new[i] = 1'h1; // R6
                next_r.rx_out.aux[i] = r.mode ? '0 : r.rxd_s3.aux[i];
                next_r.rx_out.main.wide[i] = r.mode ? low_only(r.rxd_s3.main.wide[i]) :
                    r.rxd_s3.main.wide[i];
            end
        end
        for (int j = 0; j < sldi_pkg::NARROW_LANES; j++) begin
            if (tx_edge[j + sldi_pkg::WIDE_LANES]) begin
                next_r.tx_out.main.narrow[j] = r.stage.main.narrow[j]; // R1 R3 R12
            end
            if (r.rst_s2[j + sldi_pkg::WIDE_LANES]) begin
                next_r.rx_out.main.narrow[j] = '0; // R10
            end else if (rx_edge[j + sldi_pkg::WIDE_LANES]) begin
                next_r.rx_new[j + sldi_pkg::WIDE_LANES] = 1'h1; // R6
                next_r.rx_out.main.narrow[j] = r.rxd_s3.main.narrow[j];
            end
        end
        if (RESET) begin
            next_r = '0;
            next_r.mode = sldi_pkg::MODE_RESET;
            next_r.stage = sldi_pkg::LANES_RESET;
        end
    end

    always_ff @(posedge REF_CLK) begin
        r <= next_r;
    end

    // Checks on the wide transmit and receive lanes.
    for (genvar g = 0; g < sldi_pkg::WIDE_LANES; g++) begin : g_wide_chk
        lane_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R12
            !tx_edge[g] |=> $stable(TX_LANE_MAIN_WORD.wide[g]) && $stable(TX_LANE_AUX_GROUP[g]))
            else $error("Wide transmit lane changed without its clock edge.");
        wide_copy_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R5
            tx_edge[g] && !r.mode |=> TX_LANE_AUX_GROUP[g] == $past(r.stage.aux[g]) &&
            TX_LANE_MAIN_WORD.wide[g] == $past(r.stage.main.wide[g]))
            else $error("Wide transmit lane did not carry the staged word.");
        caui10_low_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R4
            tx_edge[g] && r.mode |=> TX_LANE_AUX_GROUP[g] == '0 &&
            TX_LANE_MAIN_WORD.wide[g][sldi_pkg::WIDE_W-1:sldi_pkg::NARROW_W] == '0)
            else $error("Ten-lane mode drove bits above the low word.");
        rx_wide_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            rx_edge[g] && !r.rst_s2[g] && !r.mode |=> RX_NEW[g] &&
            RX_USER_WORD.main.wide[g] == $past(r.rxd_s3.main.wide[g]))
            else $error("Wide receive word not captured at its clock edge.");
        rx_aux_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            rx_edge[g] && !r.rst_s2[g] && !r.mode |=>
            RX_USER_WORD.aux[g] == $past(r.rxd_s3.aux[g]))
            else $error("Wide receive aux group not captured at its clock edge.");
        rx_low_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            rx_edge[g] && !r.rst_s2[g] && r.mode |=> RX_USER_WORD.aux[g] == '0 &&
            RX_USER_WORD.main.wide[g][sldi_pkg::WIDE_W-1:sldi_pkg::NARROW_W] == '0 &&
            RX_USER_WORD.main.wide[g][sldi_pkg::NARROW_W-1:0] ==
            $past(r.rxd_s3.main.wide[g][sldi_pkg::NARROW_W-1:0]))
            else $error("Ten-lane receive word not kept to its low bits.");
        rx_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R10
            r.rst_s2[g] |=> RX_USER_WORD.aux[g] == '0 && RX_USER_WORD.main.wide[g] == '0)
            else $error("Wide receive word kept while its lane was in reset.");
        rx_wide_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            !rx_edge[g] && !r.rst_s2[g] |=>
            $stable(RX_USER_WORD.aux[g]) && $stable(RX_USER_WORD.main.wide[g]))
            else $error("Wide receive word changed without its clock edge.");
    end

    // Checks on the narrow lanes and the per-lane receive new flag and reset.
    for (genvar k = 0; k < sldi_pkg::NARROW_LANES; k++) begin : g_narrow_chk
        narrow_copy_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R3
            tx_edge[k + sldi_pkg::WIDE_LANES] |=>
            TX_LANE_MAIN_WORD.narrow[k] == $past(r.stage.main.narrow[k]) ##1
            $stable(TX_LANE_MAIN_WORD.narrow[k]))
            else $error("Narrow transmit lane did not carry the staged word.");
        rx_narrow_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            rx_edge[k + sldi_pkg::WIDE_LANES] && !r.rst_s2[k + sldi_pkg::WIDE_LANES] |=>
            RX_USER_WORD.main.narrow[k] == $past(r.rxd_s3.main.narrow[k]))
            else $error("Narrow receive word not captured at its clock edge.");
        narrow_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R12
            !tx_edge[k + sldi_pkg::WIDE_LANES] |=> $stable(TX_LANE_MAIN_WORD.narrow[k]))
            else $error("Narrow transmit lane changed without its clock edge.");
        rx_narrow_clear_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R10
            r.rst_s2[k + sldi_pkg::WIDE_LANES] |=> RX_USER_WORD.main.narrow[k] == '0)
            else $error("Narrow receive word kept while its lane was in reset.");
        rx_narrow_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            !rx_edge[k + sldi_pkg::WIDE_LANES] && !r.rst_s2[k + sldi_pkg::WIDE_LANES] |=>
            $stable(RX_USER_WORD.main.narrow[k]))
            else $error("Narrow receive word changed without its clock edge.");
    end

    for (genvar m = 0; m < sldi_pkg::LANES; m++) begin : g_lane_chk
        rx_reset_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R10
            r.rst_s2[m] |=> !RX_NEW[m])
            else $error("Receive word flagged while its lane was in reset.");
        rx_pulse_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            RX_NEW[m] |=> !RX_NEW[m])
            else $error("Receive new flag lasted longer than one cycle.");
        rx_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R6
            !rx_edge[m] |=> !RX_NEW[m])
            else $error("Receive new flag raised without a lane clock edge.");
    end

    // Checks on the shared stage word.
    stage_hold_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R12
        !tx_edge[0] |=> $stable(r.stage))
        else $error("Stage word changed without a lane zero edge.");
    stage_fill_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R12
        tx_edge[0] && fifo_valid |=> r.stage == $past(fifo_word))
        else $error("Stage word did not take the oldest FIFO word.");
    stage_repeat_a: assert property (@(posedge REF_CLK) disable iff (RESET) // R12
        tx_edge[0] && !fifo_valid |=> $stable(r.stage))
        else $error("Stage word changed while the FIFO was empty.");
endmodule : sldi_top

`default_nettype wire

// >>> tb/serdes_lane_data_interface_tb_top.sv
// Purpose: Self-checking bench of the lane data interface.
// Assumes: Lane clocks of equal phase, so all lanes update together.
// Notes: Each mode fills the transmit FIFO, then runs the lanes.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: value mismatch", $time); end end

module serdes_lane_data_interface_tb_top;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic MODE_CAUI10 = 1'b0;
    logic TX_VALID = 1'b0;
    logic TX_READY;
    logic run = 1'b0;
    logic [sldi_pkg::LANES-1:0] RX_NEW, TX_LANE_CLOCK, RX_LANE_RECOVERED_CLOCK, RX_LANE_RESET;
    logic [sldi_pkg::WIDE_LANES-1:0][sldi_pkg::AUX_W-1:0] TX_LANE_AUX_GROUP, RX_LANE_AUX_GROUP;
    sldi_pkg::sldi_main_t TX_LANE_MAIN_WORD, RX_LANE_MAIN_WORD;
    sldi_pkg::sldi_lanes_t TX_USER_WORD = '0, RX_USER_WORD, rx_word = '0, rx_exp, cur, prev, w;
    sldi_pkg::sldi_lanes_t txq[$];
    int err_total = 0, n_checks = 0, seed = 50, cyc = 0, n_rx = 0, n_acc;

    always #5 REF_CLK = ~REF_CLK;

    sldi_top #(.FIFO_DEPTH(sldi_pkg::FIFO_DEPTH)) dut (.REF_CLK(REF_CLK), .RESET(RESET),
        .MODE_CAUI10(MODE_CAUI10), .TX_USER_WORD(TX_USER_WORD), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .RX_USER_WORD(RX_USER_WORD), .RX_NEW(RX_NEW),
        .TX_LANE_CLOCK(TX_LANE_CLOCK), .TX_LANE_AUX_GROUP(TX_LANE_AUX_GROUP),
        .TX_LANE_MAIN_WORD(TX_LANE_MAIN_WORD), .RX_LANE_RECOVERED_CLOCK(RX_LANE_RECOVERED_CLOCK),
        .RX_LANE_RESET(RX_LANE_RESET), .RX_LANE_AUX_GROUP(RX_LANE_AUX_GROUP),
        .RX_LANE_MAIN_WORD(RX_LANE_MAIN_WORD));

    sldi_xcvr_model far (.run(run), .rx_word(rx_word), .tx_lane_clock(TX_LANE_CLOCK),
        .rx_lane_recovered_clock(RX_LANE_RECOVERED_CLOCK), .rx_lane_reset(RX_LANE_RESET),
        .rx_lane_aux_group(RX_LANE_AUX_GROUP), .rx_lane_main_word(RX_LANE_MAIN_WORD));

    // Ten-lane mode leaves the aux groups and high halves of the wide lanes at zero.
    function automatic sldi_pkg::sldi_lanes_t fit(input sldi_pkg::sldi_lanes_t v, input logic m);
        fit = v;
        if (m) begin
            fit.aux = '0;
            for (int i = 0; i < sldi_pkg::WIDE_LANES; i++) fit.main.wide[i][63:32] = '0;
        end
    endfunction : fit

    task automatic rand_word(output sldi_pkg::sldi_lanes_t v);
        for (int k = 0; k < $bits(v) / 32; k++) v[k*32 +: 32] = $random(seed);
    endtask : rand_word

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // Every change of the lane outputs must be the oldest word still owed.
    always @(negedge REF_CLK) begin
        cur = {TX_LANE_AUX_GROUP, TX_LANE_MAIN_WORD};
        if (!RESET && cur !== prev) begin
            if (txq.size() == 0) `CHK(1'b1, 1'b0)
            else `CHK(cur, txq.pop_front())
        end
        prev = cur;
        if (!RESET && RX_NEW !== '0) begin
            n_rx++;
            `CHK(RX_NEW, {sldi_pkg::LANES{1'b1}})
            `CHK(RX_USER_WORD, rx_exp)
        end
    end

    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        repeat (8) @(negedge REF_CLK);
        for (int m = 0; m < 2; m++) begin
            RESET = 1'b1;
            MODE_CAUI10 = m[0];
            repeat (2) @(negedge REF_CLK);
            RESET = 1'b0;
            @(negedge REF_CLK);
            `CHK(TX_READY, 1'b1)
            rand_word(rx_word);
            rx_exp = fit(rx_word, m[0]);
            n_acc = 0;
            n_rx = 0;
            for (int k = 0; k < sldi_pkg::FIFO_DEPTH + 2; k++) begin
                rand_word(w);
                TX_USER_WORD = w;
                TX_VALID = 1'b1;
                if (TX_READY === 1'b1) begin
                    n_acc++;
                    txq.push_back(fit(w, m[0]));
                end
                @(negedge REF_CLK);
            end
            TX_VALID = 1'b0;
            `CHK(n_acc, sldi_pkg::FIFO_DEPTH)
            run = 1'b1;
            repeat (700) @(negedge REF_CLK);
            run = 1'b0;
            `CHK(txq.size(), 0)
            `CHK(n_rx > 20, 1'b1)
            $display("test mode %0d done", m);
        end
        test_done();
    end
endmodule : serdes_lane_data_interface_tb_top

`default_nettype wire

// >>> tb/sldi_xcvr_model.sv
// Purpose: Transceiver lanes facing the lane data interface.
// Assumes: All lanes share one 160 ns clock that runs only while run is high.
// Notes: Receive data changes on falling lane edges and inverts when stopped.
`timescale 1ns/1ps
`default_nettype none

module sldi_xcvr_model (
    // Control from the bench.
    input wire logic run,
    input wire sldi_pkg::sldi_lanes_t rx_word,
    // Lane clocks and resets.
    output logic [sldi_pkg::LANES-1:0] tx_lane_clock,
    output logic [sldi_pkg::LANES-1:0] rx_lane_recovered_clock,
    output logic [sldi_pkg::LANES-1:0] rx_lane_reset,
    // Receive lane words.
    output logic [sldi_pkg::WIDE_LANES-1:0][sldi_pkg::AUX_W-1:0] rx_lane_aux_group,
    output sldi_pkg::sldi_main_t rx_lane_main_word
);
    logic ck = 1'b0;
    int locked = 0;
    sldi_pkg::sldi_lanes_t rd = '0;
    sldi_pkg::sldi_lanes_t shown;

    always begin
        #80;
        ck = run ? ~ck : 1'b0;
    end
    // Lock is lost as soon as the clock stops and regained after four rises.
    always @(posedge ck or negedge run) begin
        if (!run) locked <= 0;
        else if (locked < 4) locked <= locked + 1;
    end
    assign rx_lane_reset = {sldi_pkg::LANES{!run || locked < 4}};
    assign tx_lane_clock = {sldi_pkg::LANES{ck}};
    assign rx_lane_recovered_clock = {sldi_pkg::LANES{ck}};
    // Data is stable at each rising edge; a stopped lane shows the inverse of its last word.
    always @(negedge ck) begin
        if (run) rd <= rx_word;
    end
    assign shown = run ? rd : ~rd;
    assign rx_lane_aux_group = shown.aux;
    assign rx_lane_main_word = shown.main;
endmodule : sldi_xcvr_model

`default_nettype wire
